//--- verilog/rts_status_bank.sv
// Purpose: Status bank for radio transmit queue and control machine
// Assumes: Single clock, synchronous reset, events one cycle wide
// Notes: Queue level and threshold come in as live counts
//
// Functional notes
// - Set sync-sent bit 4 when sync word last bit leaves modulator.
// - Full bit 3 rises at maximum count, falls below threshold.
// - Level bit 2 high while count at or above threshold.
// - Overrun bit 1 set on write into full queue until flush.
// - Starved bit 0 set when queue empties mid-packet until flush.
// - Hold 8-bit cause code for the host wake line.
// - Cause 03 after 16 consecutive listen slots without reception.
// - Dropped packet cause: length 04, address 05, CRC 06.
// - Cause 07 transmit overflow, 08 transmit underflow.
// - Cause 09 receive overflow, 0A receive underflow.
// - Cause 40 after transmit done, 80 after receive done.
// - Control bit 2 gives clear-channel outcome after check-done.
// - Control bit 0 set after first slow oscillator calibration.
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
module rts_status_bank
  import rts_pkg::*;
#(
  parameter int QUEUE_DEPTH = 128
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  // Queue state
  input wire logic [7:0] tx_queue_count_in,
  input wire logic [7:0] tx_queue_threshold_in,
  // Radio events
  input wire rts_event_s event_in,
  // Outputs
  output logic host_wake_line_out,
  output logic clear_channel_tx_refused_out,
  output logic slow_osc_trimmed_out,
  output logic irq_out
);

  // Depth truncated to the 8-bit count port
  localparam logic [7:0] QUEUE_MAX = 8'(QUEUE_DEPTH);
  // Implemented trim bits in offset order
  localparam logic [7:0] TRIM_MASK [7] = '{
    MASK_AMP_TRIM,
    MASK_SYNTH_RF,
    MASK_PRESC_TEST,
    MASK_PRESC_OVR,
    MASK_CONV_TEST,
    MASK_DIVC_TEST,
    MASK_PROBE_SEL
  };
  localparam logic [7:0] TRIM_RST [7] = '{
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_ZERO,
    RST_DIVC_TEST,
    RST_PROBE_SEL
  };

  // Transmit queue flags
  logic sync_sent_q;
  logic sync_sent_d;
  logic full_q;
  logic full_d;
  logic overrun_q;
  logic overrun_d;
  logic starved_q;
  logic starved_d;

  // Control machine state
  logic [7:0] cause_q;
  logic [7:0] cause_d;
  logic [7:0] cause_new;
  logic cca_refused_q;
  logic cca_refused_d;
  logic osc_trimmed_q;
  logic osc_trimmed_d;
  logic [4:0] miss_q;
  logic [4:0] miss_d;
  logic wake_q;
  logic wake_d;

  // Register file and interrupts
  logic [7:0] trim_q [7];
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_mask_d;
  logic [IRQ_W-1:0] irq_set;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  // Decode trim offset to array index
  function automatic logic [3:0] trim_idx(input logic [3:0] a);
    trim_idx = a - OFF_AMP_TRIM;
  endfunction

  // Write strobe aimed at one offset
  function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] off);
    wr_hit = wr && (a == off);
  endfunction

  // Sticky flag, set wins over clear
  function automatic logic sticky(input logic set, input logic held, input logic clr);
    sticky = set || (held && !clr);
  endfunction

  wire logic [3:0] wr_idx = trim_idx(reg_addr_in);
  wire logic [3:0] rd_idx = trim_idx(reg_addr_in);
  wire logic is_trim = reg_addr_in >= OFF_AMP_TRIM && reg_addr_in <= OFF_PROBE_SEL;
  wire logic stat_wr = wr_hit(reg_wr_in, reg_addr_in, OFF_IRQ_STATUS);
  wire logic mask_wr = wr_hit(reg_wr_in, reg_addr_in, OFF_IRQ_MASK);

  wire logic at_level = tx_queue_count_in >= tx_queue_threshold_in;
  wire logic at_max = tx_queue_count_in >= QUEUE_MAX;
  wire logic overrun_evt = event_in.host_write && at_max;

  assign sync_sent_d = sticky(event_in.sync_sent, sync_sent_q, 1'b0);
  always_comb
  begin
    full_d = 1'b0;
    if (at_max)
      full_d = 1'b1;
    else if (at_level)
      full_d = full_q;
  end
  assign overrun_d = sticky(overrun_evt, overrun_q, event_in.queue_flush);
  assign starved_d = sticky(event_in.queue_empty_mid_pkt, starved_q, event_in.queue_flush);

  wire logic slot_miss = event_in.listen_slot_end && !event_in.listen_slot_ok;
  wire logic listen_lost = slot_miss && (miss_q == LISTEN_LOST_SLOTS - 5'h01);
  // Restart on success, and once loss is reported
  wire logic miss_restart = event_in.listen_slot_ok || listen_lost;
  // Never passes fifteen, so five bits suffice
  assign miss_d = miss_restart ? 5'h00 : (slot_miss ? miss_q + 5'h01 : miss_q);

  always_comb
  begin
    cause_new = CAUSE_NONE;
    if (event_in.rx_timeout)
      cause_new = CAUSE_RX_TIMEOUT;
    if (event_in.rx_term)
      cause_new = CAUSE_RX_TERM;
    if (listen_lost)
      cause_new = CAUSE_LISTEN_LOST;
    if (event_in.drop_len)
      cause_new = CAUSE_DROP_LEN;
    if (event_in.drop_addr)
      cause_new = CAUSE_DROP_ADDR;
    if (event_in.drop_crc)
      cause_new = CAUSE_DROP_CRC;
    if (overrun_evt)
      cause_new = CAUSE_TXQ_OVER;
    if (event_in.queue_empty_mid_pkt)
      cause_new = CAUSE_TXQ_UNDER;
    if (event_in.rxq_over)
      cause_new = CAUSE_RXQ_OVER;
    if (event_in.rxq_under)
      cause_new = CAUSE_RXQ_UNDER;
    if (event_in.tx_done)
      cause_new = CAUSE_TX_DONE;
    if (event_in.rx_done)
      cause_new = CAUSE_RX_DONE;
  end

  wire logic cause_evt = cause_new != CAUSE_NONE;
  assign cause_d = cause_evt ? cause_new : cause_q;
  // Wake pulse follows any cause update
  assign wake_d = cause_evt;

  assign cca_refused_d = event_in.cca_done ? event_in.cca_busy : cca_refused_q;
  assign osc_trimmed_d = sticky(event_in.osc_cal_done, osc_trimmed_q, 1'b0);

  // Interrupt sources
  assign irq_set[IRQ_CAUSE] = cause_evt;
  assign irq_set[IRQ_SYNC_SENT] = event_in.sync_sent;
  assign irq_set[IRQ_OVERRUN] = overrun_evt;
  assign irq_set[IRQ_STARVED] = event_in.queue_empty_mid_pkt;
  assign irq_set[IRQ_CCA_DONE] = event_in.cca_done;
  assign irq_set[IRQ_OSC_TRIMMED] = event_in.osc_cal_done;

  // Set wins over a same-cycle write-one clear
  for (genvar b = 0; b < IRQ_W; b++)
  begin : g_irq
    assign irq_stat_d[b] = sticky(irq_set[b], irq_stat_q[b], stat_wr && reg_wdata_in[b]);
  end
  // Mask is plain storage
  assign irq_mask_d = mask_wr ? reg_wdata_in[IRQ_W-1:0] : irq_mask_q;

  // Register views, reserved bits tied low
  wire logic [7:0] view_txq = {3'h0, sync_sent_q, full_q, at_level, overrun_q, starved_q};
  wire logic [7:0] view_ctrl = {5'h00, cca_refused_q, 1'b0, osc_trimmed_q};
  wire logic [7:0] view_stat = {2'h0, irq_stat_q};
  wire logic [7:0] view_mask = {2'h0, irq_mask_q};
  wire logic [7:0] view_trim = is_trim ? trim_q[rd_idx[2:0]] : 8'h00;

  // Read select, unmapped offsets read zero
  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        OFF_TXQ_FLAGS: rdata_d = view_txq;
        OFF_CAUSE: rdata_d = cause_q;
        OFF_CTRL_FLAGS: rdata_d = view_ctrl;
        OFF_IRQ_STATUS: rdata_d = view_stat;
        OFF_IRQ_MASK: rdata_d = view_mask;
        default: rdata_d = view_trim;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      sync_sent_q <= 1'b0;
    else
      sync_sent_q <= sync_sent_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      full_q <= 1'b0;
    else
      full_q <= full_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      overrun_q <= 1'b0;
    else
      overrun_q <= overrun_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      starved_q <= 1'b0;
    else
      starved_q <= starved_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cause_q <= CAUSE_NONE;
    else
      cause_q <= cause_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      miss_q <= 5'h00;
    else
      miss_q <= miss_d;
  end

  // Wake pulse, one cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      wake_q <= 1'b0;
    else
      wake_q <= wake_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cca_refused_q <= 1'b0;
    else
      cca_refused_q <= cca_refused_d;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      osc_trimmed_q <= 1'b0;
    else
      osc_trimmed_q <= osc_trimmed_d;
  end

  // Interrupt status
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_stat_q <= '0;
    else
      irq_stat_q <= irq_stat_d;
  end

  // Interrupt mask
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      irq_mask_q <= '0;
    else
      irq_mask_q <= irq_mask_d;
  end

  // Read data stands one cycle only
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  // Test trims, only implemented bits store
  for (genvar i = 0; i < 7; i++)
  begin : g_trim
    always_ff @(posedge clk_in)
    begin
      if (rst_in)
      begin
        trim_q[i] <= TRIM_RST[i];
      end
      else if (reg_wr_in && is_trim && wr_idx == 4'(i))
      begin
        trim_q[i] <= reg_wdata_in & TRIM_MASK[i];
      end
    end
  end

  // Outputs straight from flops, irq_out from masked status flops
  assign reg_rdata_out = rdata_q;
  assign host_wake_line_out = wake_q;
  assign clear_channel_tx_refused_out = cca_refused_q;
  assign slow_osc_trimmed_out = osc_trimmed_q;
  assign irq_out = |(irq_stat_q & irq_mask_q);
endmodule

//--- pkg/rts_pkg.sv
// Purpose: Constants and types for the radio transmit and control status bank
// Assumes: 8-bit registers on a plain address/strobe port
// Notes: Offsets are local choices; test trims are plain storage
package rts_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] OFF_TXQ_FLAGS = 4'h0;
  localparam logic [3:0] OFF_CAUSE = 4'h1;
  localparam logic [3:0] OFF_CTRL_FLAGS = 4'h2;
  localparam logic [3:0] OFF_AMP_TRIM = 4'h3;
  localparam logic [3:0] OFF_SYNTH_RF = 4'h4;
  localparam logic [3:0] OFF_PRESC_TEST = 4'h5;
  localparam logic [3:0] OFF_PRESC_OVR = 4'h6;
  localparam logic [3:0] OFF_CONV_TEST = 4'h7;
  localparam logic [3:0] OFF_DIVC_TEST = 4'h8;
  localparam logic [3:0] OFF_PROBE_SEL = 4'h9;
  localparam logic [3:0] OFF_IRQ_STATUS = 4'hA;
  localparam logic [3:0] OFF_IRQ_MASK = 4'hB;
  // Field positions
  localparam int TXQ_SYNC_SENT_BIT = 4;
  localparam int TXQ_FULL_BIT = 3;
  localparam int TXQ_LEVEL_BIT = 2;
  localparam int TXQ_OVERRUN_BIT = 1;
  localparam int TXQ_STARVED_BIT = 0;
  localparam int CTRL_CCA_REFUSED_BIT = 2;
  localparam int CTRL_OSC_TRIMMED_BIT = 0;
  // Writable field masks
  localparam logic [7:0] MASK_AMP_TRIM = 8'h1F;
  localparam logic [7:0] MASK_SYNTH_RF = 8'h7F;
  localparam logic [7:0] MASK_PRESC_TEST = 8'h1F;
  localparam logic [7:0] MASK_PRESC_OVR = 8'hFF;
  localparam logic [7:0] MASK_CONV_TEST = 8'h3F;
  localparam logic [7:0] MASK_DIVC_TEST = 8'h1F;
  localparam logic [7:0] MASK_PROBE_SEL = 8'h7F;
  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_DIVC_TEST = 8'h0B;
  localparam logic [7:0] RST_PROBE_SEL = 8'h40;
  // Cause codes
  localparam logic [7:0] CAUSE_NONE = 8'h00;
  localparam logic [7:0] CAUSE_RX_TIMEOUT = 8'h01;
  localparam logic [7:0] CAUSE_RX_TERM = 8'h02;
  localparam logic [7:0] CAUSE_LISTEN_LOST = 8'h03;
  localparam logic [7:0] CAUSE_DROP_LEN = 8'h04;
  localparam logic [7:0] CAUSE_DROP_ADDR = 8'h05;
  localparam logic [7:0] CAUSE_DROP_CRC = 8'h06;
  localparam logic [7:0] CAUSE_TXQ_OVER = 8'h07;
  localparam logic [7:0] CAUSE_TXQ_UNDER = 8'h08;
  localparam logic [7:0] CAUSE_RXQ_OVER = 8'h09;
  localparam logic [7:0] CAUSE_RXQ_UNDER = 8'h0A;
  localparam logic [7:0] CAUSE_TX_DONE = 8'h40;
  localparam logic [7:0] CAUSE_RX_DONE = 8'h80;
  localparam logic [4:0] LISTEN_LOST_SLOTS = 5'h10;
  // Interrupt status bits
  localparam int IRQ_W = 6;
  localparam int IRQ_CAUSE = 0;
  localparam int IRQ_SYNC_SENT = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam int IRQ_STARVED = 3;
  localparam int IRQ_CCA_DONE = 4;
  localparam int IRQ_OSC_TRIMMED = 5;

  // Radio events, each a one-cycle pulse
  typedef struct packed {
    logic sync_sent;
    logic host_write;
    logic queue_flush;
    logic queue_empty_mid_pkt;
    logic rx_timeout;
    logic rx_term;
    logic listen_slot_end;
    logic listen_slot_ok;
    logic drop_len;
    logic drop_addr;
    logic drop_crc;
    logic rxq_over;
    logic rxq_under;
    logic tx_done;
    logic rx_done;
    logic cca_done;
    logic cca_busy;
    logic osc_cal_done;
  } rts_event_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } rts_bus_s;
endpackage

//--- tb/rts_status_assertions.sv
// Purpose: Port checks for the radio status bank
// Assumes: One clock, synchronous reset, threshold not above queue depth
// Notes: Bound into every bank instance
`timescale 1ns/100ps
module rts_status_assertions
  import rts_pkg::*;
#(
  parameter int QUEUE_DEPTH = 128
)
(
  // Clock and register port
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [DATA_W-1:0] reg_rdata_out,
  // Queue state and events
  input wire logic [7:0] tx_queue_count_in,
  input wire logic [7:0] tx_queue_threshold_in,
  input wire rts_event_s event_in,
  // Watched outputs
  input wire logic host_wake_line_out,
  input wire logic clear_channel_tx_refused_out,
  input wire logic slow_osc_trimmed_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire rd_flags = reg_rd_in && reg_addr_in == OFF_TXQ_FLAGS;
  wire rd_cause = reg_rd_in && reg_addr_in == OFF_CAUSE;
  wire lvl = tx_queue_count_in >= tx_queue_threshold_in;
  wire at_max = tx_queue_count_in >= QUEUE_DEPTH;
  rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
    else $error("read data not zero while idle");
  flag_rsvd_a: assert property (rd_flags |=> reg_rdata_out[7:5] == 3'h0)
    else $error("reserved flag bits set");
  level_bit_a: assert property (rd_flags |=> reg_rdata_out[2] == $past(lvl))
    else $error("level flag wrong");
  full_bit_a: assert property (at_max [*2] ##0 rd_flags |=> reg_rdata_out[3])
    else $error("full flag missing");
  wake_pulse_a: assert property (event_in.tx_done |=> host_wake_line_out)
    else $error("wake line not raised");
  rx_cause_a: assert property (event_in.rx_done ##1 (rd_cause && event_in == '0)
    |=> reg_rdata_out == CAUSE_RX_DONE) else $error("receive cause wrong");
  cca_out_a: assert property (event_in.cca_done
    |=> clear_channel_tx_refused_out == $past(event_in.cca_busy)) else $error("cca outcome");
  osc_set_a: assert property (event_in.osc_cal_done |=> slow_osc_trimmed_out)
    else $error("trim flag not set");
  osc_keep_a: assert property ($past(slow_osc_trimmed_out) |-> slow_osc_trimmed_out)
    else $error("trim flag dropped");
  cover property (event_in.host_write && at_max);
  cover property (rd_cause);
  cover property (irq_out);
endmodule
bind rts_status_bank rts_status_assertions #(.QUEUE_DEPTH(QUEUE_DEPTH)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .tx_queue_count_in(tx_queue_count_in), .tx_queue_threshold_in(tx_queue_threshold_in),
  .event_in(event_in), .host_wake_line_out(host_wake_line_out), .irq_out(irq_out),
  .clear_channel_tx_refused_out(clear_channel_tx_refused_out),
  .slow_osc_trimmed_out(slow_osc_trimmed_out));

//--- tb/rts_host_model.sv
// Purpose: Host side of the register port
// Assumes: Strobes one cycle, data the cycle after a read
// Notes: Leaves a cycle between accesses
`timescale 1ns/100ps
module rts_host_model
  import rts_pkg::*;
(
  // Clock and read data
  input wire logic clk_in,
  input wire logic [DATA_W-1:0] rdata_in,
  // Bus request
  output rts_bus_s bus_out
);
  initial bus_out = '0;
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    bus_out.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_in);
    bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    bus_out.rd <= 1'b0;
    #1;
    v = rdata_in;
  endtask
endmodule

//--- tb/tb.sv
// Purpose: Register level test of the radio status bank
// Assumes: Event pulses one cycle, queue count driven as a level
// Notes: Unmapped and status writes checked with an all-ones sweep
`timescale 1ns/100ps
module tb;
  import rts_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] cnt = 8'h00;
  logic [7:0] thr = 8'h40;
  rts_event_s ev = '0;
  rts_bus_s bus;
  logic [7:0] rdata, d;
  logic wake, refused, trimmed, irq;
  int n_fail = 0;
  int tests_run = 0;
  logic [7:0] rst_v [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 8'h0B, 8'h40, 0, 0, 0, 0, 0, 0};
  logic [7:0] one_v [16] = '{0, 0, 0, 8'h1F, 8'h7F, 8'h1F, 8'hFF, 8'h3F, 8'h1F, 8'h7F,
    0, 8'h3F, 0, 0, 0, 0};
  // Event bit, then the cause it leaves
  int cb [10] = '{13, 12, 9, 8, 7, 14, 6, 5, 4, 3};
  logic [7:0] cc [10] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h40, 8'h80};
  initial forever #20 clk_in = ~clk_in;
  rts_status_bank dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(bus.addr),
    .reg_wdata_in(bus.wdata), .reg_wr_in(bus.wr), .reg_rd_in(bus.rd), .reg_rdata_out(rdata),
    .tx_queue_count_in(cnt), .tx_queue_threshold_in(thr), .event_in(ev),
    .host_wake_line_out(wake), .clear_channel_tx_refused_out(refused),
    .slow_osc_trimmed_out(trimmed), .irq_out(irq));
  rts_host_model host (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic pulse(input logic [17:0] m);
    @(posedge clk_in);
    ev <= rts_event_s'(m);
    @(posedge clk_in);
    ev <= '0;
    #1;
  endtask
  task automatic setc(input logic [7:0] v);
    @(posedge clk_in);
    cnt <= v;
  endtask
  task automatic ci(input logic e);
    #1;
    chk({7'h0, irq}, {7'h0, e});
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_fail++;
    close_out();
  end
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int a = 0; a < 16; a++)
      rc(4'(a), rst_v[a]);
    for (int a = 0; a < 16; a++)
      host.wr(4'(a), 8'hFF);
    for (int a = 0; a < 16; a++)
      rc(4'(a), one_v[a]);
    for (int i = 0; i < 10; i++)
    begin
      pulse(18'h1 << cb[i]);
      chk({7'h0, wake}, 8'h01);
      rc(OFF_CAUSE, cc[i]);
      chk({7'h0, wake}, 8'h00);
    end
    // Fifteen missed slots must not report loss yet
    repeat (15) pulse(18'h1 << 11);
    rc(OFF_CAUSE, 8'h80);
    pulse(18'h1 << 11);
    rc(OFF_CAUSE, 8'h03);
    pulse(18'h1 << 15);
    rc(OFF_TXQ_FLAGS, 8'h00);
    setc(8'h80);
    rc(OFF_TXQ_FLAGS, 8'h0C);
    pulse(18'h1 << 16);
    rc(OFF_TXQ_FLAGS, 8'h0E);
    rc(OFF_CAUSE, 8'h07);
    setc(8'h64);
    rc(OFF_TXQ_FLAGS, 8'h0E);
    setc(8'h0A);
    rc(OFF_TXQ_FLAGS, 8'h02);
    pulse(18'h1 << 14);
    rc(OFF_TXQ_FLAGS, 8'h03);
    pulse(18'h1 << 17);
    rc(OFF_TXQ_FLAGS, 8'h13);
    pulse(18'h1 << 15);
    rc(OFF_TXQ_FLAGS, 8'h10);
    pulse(18'h6);
    chk({7'h0, refused}, 8'h01);
    rc(OFF_CTRL_FLAGS, 8'h04);
    pulse(18'h1);
    chk({7'h0, trimmed}, 8'h01);
    rc(OFF_CTRL_FLAGS, 8'h05);
    pulse(18'h4);
    chk({7'h0, refused}, 8'h00);
    rc(OFF_CTRL_FLAGS, 8'h01);
    ci(1'b1);
    host.wr(OFF_IRQ_STATUS, 8'h3F);
    ci(1'b0);
    host.wr(OFF_IRQ_MASK, 8'h00);
    pulse(18'h1 << 17);
    rc(OFF_IRQ_STATUS, 8'h02);
    ci(1'b0);
    host.wr(OFF_IRQ_MASK, 8'h02);
    ci(1'b1);
    host.wr(OFF_IRQ_STATUS, 8'h02);
    ci(1'b0);
    close_out();
  end
endmodule
